/* emif_core.v */
// External data-memory interface: address mapping, on-chip RAM steering and programmable bus timing
//
// How it works
// (R1) In split bank-select mode addresses below the RAM size go to on-chip RAM and the rest off-chip.
// (R2) In split bank-select mode an 8-bit move builds A[15:8] from the page register and A[7:0] from the pointer.
// (R3) In split bank-select mode a 16-bit move decides by the data pointer and drives all sixteen bits off-chip.
// (R4) In external-only mode every move goes off-chip and on-chip RAM is never reached.
// (R5) In external-only mode an 8-bit move ignores the page and leaves the upper address pins to the port latch.
// (R6) In external-only mode a 16-bit move uses the data pointer and drives all sixteen address bits.
// (R7) Setup, hold, strobe width and latch width are programmable in whole clock periods.
// (R8) An off-chip move lasts the programmed cycles plus four fixed cycles.
// (R9) The shortest non-multiplexed off-chip move is a one-cycle strobe plus four, five cycles.
// (R10) The multiplexed latch phase adds at least two cycles, seven cycles at the shortest.
// (R11) Setup and hold times reset to their largest settings.
// (R12) The CPU is held until every cycle of an off-chip move is done before data returns.
`timescale 1ns/100ps
`include "emif_regs.vh"
module emif_core #(
  parameter RAM_SIZE = 4096,
  parameter RAM_AW   = 12
) (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_rst,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // CPU move request
  input  wire        i_cpu_req,
  input  wire        i_cpu_wr,
  input  wire        i_cpu_wide,
  input  wire [15:0] i_cpu_data_pointer,
  input  wire [7:0]  i_cpu_ptr,
  input  wire [7:0]  i_cpu_wdata,
  output reg         o_cpu_busy,
  output reg         o_cpu_done,
  output reg  [7:0]  o_cpu_rdata,
  // Port latch value shown on undriven upper address pins
  input  wire [7:0]  i_port_hi,
  // External bus pins
  output reg  [15:0] o_addr,
  output reg         o_addr_hi_oe,
  output reg         o_addr_lo_oe,
  output reg  [7:0]  o_data,
  output reg         o_data_oe,
  input  wire [7:0]  i_data,
  output reg         o_ale,
  output reg         o_rd_n,
  output reg         o_wr_n
);

  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_RAM    = 3'd1;
  localparam [2:0] ST_LEAD   = 3'd2;
  localparam [2:0] ST_ALE    = 3'd3;
  localparam [2:0] ST_SETUP  = 3'd4;
  localparam [2:0] ST_STROBE = 3'd5;
  localparam [2:0] ST_HOLD   = 3'd6;
  localparam [2:0] ST_TAIL   = 3'd7;

  localparam [16:0] RAM_BOUND = RAM_SIZE[16:0];

  // Registers
  reg  [7:0]  cfg_r;
  reg  [7:0]  page_r;
  reg  [7:0]  tmg_r;
  reg  [7:0]  last_cyc_r;
  reg         last_off_r;

  // Access state
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [7:0]  acc_tmg_r;
  reg  [7:0]  acc_cfg_r;
  reg  [15:0] acc_addr_r;
  reg         acc_hi_r;
  reg         acc_wr_r;
  reg  [7:0]  acc_wdata_r;
  reg  [7:0]  cyc_cnt_r;
  reg  [7:0]  rd_hold_r;

  // Data pin synchroniser and filter
  reg  [7:0]  din_s1_r;
  reg  [7:0]  din_s2_r;
  reg  [7:0]  din_s3_r;
  reg  [7:0]  din_filt_r;

  wire        tmr_last;
  wire [7:0]  ram_rdata;
  reg         tmr_load;
  reg  [4:0]  tmr_len;

  wire [1:0]  mode     = cfg_r[`EMIF_CFG_MODE_HI:`EMIF_CFG_MODE_LO];
  wire        accept   = i_cpu_req & (state_r == ST_IDLE);
  wire [15:0] eff_addr = i_cpu_wide ? i_cpu_data_pointer :
                         (mode == `EMIF_MODE_EXT_ONLY) ? {8'h00, i_cpu_ptr} : {page_r, i_cpu_ptr};
  wire        go_ram   = onchip(mode, eff_addr);
  wire        hi_drive = i_cpu_wide | (mode == `EMIF_MODE_SPLIT_BS);

  // Decides whether an address lands in on-chip RAM under the given mode
  function onchip;
    input [1:0]  md;
    input [15:0] a;
    begin
      case (md)
        `EMIF_MODE_ONCHIP:   onchip = 1'b1;
        // (R4) Never on-chip
        `EMIF_MODE_EXT_ONLY: onchip = 1'b0;
        // (R1) Boundary split
        default:             onchip = ({1'b0, a} < RAM_BOUND);
      endcase
    end
  endfunction

  // Length of a phase in cycles; zero means the phase is skipped
  function [4:0] phase_len;
    input [2:0] st;
    input [7:0] tm;
    input [7:0] cf;
    begin
      case (st)
        ST_LEAD:   phase_len = `EMIF_LEAD_CYC;
        // (R10) Latch phase two cycles at least
        ST_ALE:    phase_len = cf[`EMIF_CFG_MUX_BIT] ?
                               (`EMIF_ALE_MIN_CYC + {3'b000, cf[`EMIF_CFG_ALE_HI:`EMIF_CFG_ALE_LO]}) : 5'd0;
        // (R7) Programmable setup
        ST_SETUP:  phase_len = {3'b000, tm[`EMIF_TMG_SETUP_HI:`EMIF_TMG_SETUP_LO]};
        // (R9) Strobe one cycle at least
        ST_STROBE: phase_len = {1'b0, tm[`EMIF_TMG_PW_HI:`EMIF_TMG_PW_LO]} + 5'd1;
        // (R7) Programmable hold
        ST_HOLD:   phase_len = {3'b000, tm[`EMIF_TMG_HOLD_HI:`EMIF_TMG_HOLD_LO]};
        ST_TAIL:   phase_len = `EMIF_TAIL_CYC;
        default:   phase_len = 5'd0;
      endcase
    end
  endfunction

  // Next non-empty phase after the given one
  function [2:0] next_phase;
    input [2:0] st;
    input [7:0] tm;
    input [7:0] cf;
    reg   [2:0] s;
    begin
      s = st + 3'd1;
      if (s == ST_ALE && phase_len(ST_ALE, tm, cf) == 5'd0) begin
        s = ST_SETUP;
      end
      if (s == ST_SETUP && phase_len(ST_SETUP, tm, cf) == 5'd0) begin
        s = ST_STROBE;
      end
      if (s == ST_HOLD && phase_len(ST_HOLD, tm, cf) == 5'd0) begin
        s = ST_TAIL;
      end
      next_phase = s;
    end
  endfunction

  emif_ram #(
    .AW      (RAM_AW)
  ) u_ram (
    .i_clock (i_clock),
    .i_en    (accept & go_ram),
    .i_wr    (i_cpu_wr),
    .i_addr  (eff_addr[RAM_AW-1:0]),
    .i_wdata (i_cpu_wdata),
    .o_rdata (ram_rdata)
  );

  emif_tmr u_tmr (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (tmr_load),
    .i_len   (tmr_len),
    .o_last  (tmr_last)
  );

  // Sequencer next state
  always @* begin
    state_nxt = state_r;
    tmr_load  = 1'b0;
    tmr_len   = 5'd0;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          if (go_ram) begin
            state_nxt = ST_RAM;
          end else begin
            // (R8) Two fixed lead cycles
            state_nxt = ST_LEAD;
            tmr_load  = 1'b1;
            tmr_len   = `EMIF_LEAD_CYC;
          end
        end
      end
      ST_RAM: begin
        state_nxt = ST_IDLE;
      end
      ST_TAIL: begin
        // (R12) Release only after the tail
        if (tmr_last) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        if (tmr_last) begin
          state_nxt = next_phase(state_r, acc_tmg_r, acc_cfg_r);
          tmr_load  = 1'b1;
          tmr_len   = phase_len(state_nxt, acc_tmg_r, acc_cfg_r);
        end
      end
    endcase
  end

  // Sequencer, access latch and CPU answer
  always @(posedge i_clock) begin
    if (i_rst) begin
      state_r     <= ST_IDLE;
      acc_tmg_r   <= `EMIF_TMG_RST;
      acc_cfg_r   <= `EMIF_CFG_RST;
      acc_addr_r  <= 16'h0000;
      acc_hi_r    <= 1'b0;
      acc_wr_r    <= 1'b0;
      acc_wdata_r <= 8'h00;
      cyc_cnt_r   <= 8'h00;
      rd_hold_r   <= 8'h00;
      last_cyc_r  <= 8'h00;
      last_off_r  <= 1'b0;
      o_cpu_busy  <= 1'b0;
      o_cpu_done  <= 1'b0;
      o_cpu_rdata <= 8'h00;
    end else begin
      state_r    <= state_nxt;
      o_cpu_done <= 1'b0;
      if (accept) begin
        // Timing is frozen for the whole access
        acc_tmg_r   <= tmg_r;
        acc_cfg_r   <= cfg_r;
        acc_addr_r  <= eff_addr;
        // (R2) (R3) (R5) (R6) Upper address drive
        acc_hi_r    <= hi_drive;
        acc_wr_r    <= i_cpu_wr;
        acc_wdata_r <= i_cpu_wdata;
        cyc_cnt_r   <= 8'h01;
        last_off_r  <= ~go_ram;
        o_cpu_busy  <= 1'b1;
      end else if (state_r != ST_IDLE && state_r != ST_RAM) begin
        cyc_cnt_r <= cyc_cnt_r + 8'h01;
      end
      if (state_r == ST_STROBE && tmr_last) begin
        rd_hold_r <= din_filt_r;
      end
      if (state_r == ST_RAM) begin
        o_cpu_busy  <= 1'b0;
        o_cpu_done  <= 1'b1;
        o_cpu_rdata <= ram_rdata;
      end
      // (R12) Answer after the last cycle
      if (state_r == ST_TAIL && tmr_last) begin
        o_cpu_busy  <= 1'b0;
        o_cpu_done  <= 1'b1;
        o_cpu_rdata <= acc_wr_r ? 8'h00 : rd_hold_r;
        last_cyc_r  <= cyc_cnt_r;
      end
    end
  end

  // Pin outputs follow the next phase so each one comes from a flip-flop
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_addr       <= 16'h0000;
      o_addr_hi_oe <= 1'b0;
      o_addr_lo_oe <= 1'b0;
      o_data       <= 8'h00;
      o_data_oe    <= 1'b0;
      o_ale        <= 1'b0;
      o_rd_n       <= 1'b1;
      o_wr_n       <= 1'b1;
    end else begin
      if (state_nxt == ST_IDLE || state_nxt == ST_RAM) begin
        o_addr       <= {i_port_hi, o_addr[7:0]};
        o_addr_hi_oe <= 1'b0;
        o_addr_lo_oe <= 1'b0;
        o_data_oe    <= 1'b0;
        o_ale        <= 1'b0;
        o_rd_n       <= 1'b1;
        o_wr_n       <= 1'b1;
      end else begin
        // (R5) Undriven upper bits show the port latch
        o_addr[15:8] <= (accept ? hi_drive : acc_hi_r) ? (accept ? eff_addr[15:8] : acc_addr_r[15:8]) : i_port_hi;
        o_addr[7:0]  <= accept ? eff_addr[7:0] : acc_addr_r[7:0];
        o_addr_hi_oe <= accept ? hi_drive : acc_hi_r;
        o_addr_lo_oe <= 1'b1;
        o_ale        <= (state_nxt == ST_ALE);
        o_rd_n       <= ~((state_nxt == ST_STROBE) & ~acc_wr_r);
        o_wr_n       <= ~((state_nxt == ST_STROBE) & acc_wr_r);
        if (state_nxt == ST_ALE) begin
          // Multiplexed bus carries the low address while latching
          o_data    <= acc_addr_r[7:0];
          o_data_oe <= 1'b1;
        end else begin
          o_data    <= acc_wdata_r;
          o_data_oe <= acc_wr_r & (state_nxt == ST_SETUP || state_nxt == ST_STROBE || state_nxt == ST_HOLD);
        end
      end
    end
  end

  // Data pins pass three flops; a bit changes once stages two and three agree
  always @(posedge i_clock) begin
    if (i_rst) begin
      din_s1_r   <= 8'h00;
      din_s2_r   <= 8'h00;
      din_s3_r   <= 8'h00;
      din_filt_r <= 8'h00;
    end else begin
      din_s1_r   <= i_data;
      din_s2_r   <= din_s1_r;
      din_s3_r   <= din_s2_r;
      din_filt_r <= (~(din_s2_r ^ din_s3_r) & din_s2_r) | ((din_s2_r ^ din_s3_r) & din_filt_r);
    end
  end

  // APB slave: one wait state, write and read data at the pready edge
  always @(posedge i_clock) begin
    if (i_rst) begin
      // (R11) Largest setup and hold
      cfg_r     <= `EMIF_CFG_RST;
      page_r    <= `EMIF_PAGE_RST;
      tmg_r     <= `EMIF_TMG_RST;
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      if (i_psel && i_penable && !o_pready) begin
        o_pready <= 1'b1;
        o_prdata <= 32'h0000_0000;
        if (i_paddr == `EMIF_REG_CFG) begin
          // (R7) Latch width and bus style
          if (i_pwrite) begin
            cfg_r <= i_pwdata[7:0] & `EMIF_CFG_WMASK;
          end
          o_prdata <= {24'h000000, cfg_r};
        end else if (i_paddr == `EMIF_REG_PAGE) begin
          if (i_pwrite) begin
            page_r <= i_pwdata[7:0];
          end
          o_prdata <= {24'h000000, page_r};
        end else if (i_paddr == `EMIF_REG_TMG) begin
          // (R7) Setup, strobe and hold widths
          if (i_pwrite) begin
            tmg_r <= i_pwdata[7:0];
          end
          o_prdata <= {24'h000000, tmg_r};
        end else if (i_paddr == `EMIF_REG_STAT) begin
          o_prdata  <= {16'h0000, last_cyc_r, 6'b000000, last_off_r, o_cpu_busy};
          o_pslverr <= i_pwrite;
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

endmodule // emif_core

/* emif_regs.vh */
// Register offsets, field positions, reset values and timing counts of the external memory interface
`ifndef EMIF_REGS_VH
`define EMIF_REGS_VH

// Register byte offsets
`define EMIF_REG_CFG        8'h00
`define EMIF_REG_PAGE       8'h04
`define EMIF_REG_TMG        8'h08
`define EMIF_REG_STAT       8'h0c

// emif_config fields
`define EMIF_CFG_ALE_HI     1
`define EMIF_CFG_ALE_LO     0
`define EMIF_CFG_MODE_HI    3
`define EMIF_CFG_MODE_LO    2
`define EMIF_CFG_MUX_BIT    4
`define EMIF_CFG_WMASK      8'h1f

// Mapping modes
`define EMIF_MODE_ONCHIP    2'b00
`define EMIF_MODE_SPLIT_NB  2'b01
`define EMIF_MODE_SPLIT_BS  2'b10
`define EMIF_MODE_EXT_ONLY  2'b11

// emif_timing_ctrl fields
`define EMIF_TMG_SETUP_HI   7
`define EMIF_TMG_SETUP_LO   6
`define EMIF_TMG_PW_HI      5
`define EMIF_TMG_PW_LO      2
`define EMIF_TMG_HOLD_HI    1
`define EMIF_TMG_HOLD_LO    0

// Reset values: setup, hold and latch width at their largest
`define EMIF_CFG_RST        8'h03
`define EMIF_PAGE_RST       8'h00
`define EMIF_TMG_RST        8'hff

// Fixed cycle counts in sys_clock periods
`define EMIF_LEAD_CYC       5'd2
`define EMIF_TAIL_CYC       5'd2
`define EMIF_ALE_MIN_CYC    5'd2

`endif

/* emif_ram.v */
// On-chip data RAM with one synchronous read/write port
`timescale 1ns/100ps
module emif_ram #(
  parameter AW = 12
) (
  // Clock
  input  wire          i_clock,
  // Access port
  input  wire          i_en,
  input  wire          i_wr,
  input  wire [AW-1:0] i_addr,
  input  wire [7:0]    i_wdata,
  output reg  [7:0]    o_rdata
);

  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge i_clock) begin
    if (i_en) begin
      if (i_wr) begin
        mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
    end
  end

endmodule // emif_ram

/* emif_tmr.v */
// Phase length down-counter for the off-chip access sequencer
`timescale 1ns/100ps
module emif_tmr (
  // Clock and reset
  input  wire       i_clock,
  input  wire       i_rst,
  // Control
  input  wire       i_load,
  input  wire [4:0] i_len,
  // Status
  output wire       o_last
);

  reg [4:0] cnt_r;

  always @(posedge i_clock) begin
    if (i_rst) begin
      cnt_r <= 5'h00;
    end else if (i_load) begin
      cnt_r <= i_len;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  assign o_last = (cnt_r == 5'h01);

endmodule // emif_tmr

/* emimt_mem.sv */
// Byte-wide external memory seen on the off-chip bus
`timescale 1ns/100ps
module emimt_mem (
  // Bus from the interface
  input  logic        i_clock,
  input  logic [15:0] i_addr,
  input  logic [7:0]  i_data,
  input  logic        i_rd_n,
  input  logic        i_wr_n,
  // Read data back
  output logic [7:0]  o_data
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r = 8'h00;
  always @(posedge i_clock) begin
    if (!i_wr_n) begin
      mem[i_addr] <= i_data;
    end
    if (!i_rd_n) begin
      last_r <= mem[i_addr];
    end
  end
  // Released bus shows the inverse of the last byte
  always_comb begin
    if (!i_rd_n) begin
      o_data = mem[i_addr];
    end else begin
      o_data = ~last_r;
    end
  end
endmodule // emimt_mem

/* emimt_properties.sv */
// Checker of strobe, handshake and access spacing
`timescale 1ns/100ps
module emimt_properties (
  input logic i_clock,
  input logic i_rst,
  input logic i_psel,
  input logic i_penable,
  input logic i_cpu_req,
  input logic o_pready,
  input logic o_pslverr,
  input logic o_cpu_busy,
  input logic o_cpu_done,
  input logic o_rd_n,
  input logic o_wr_n,
  input logic o_data_oe,
  input logic o_addr_lo_oe,
  input logic o_ale
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  strobe_in_move_a: assert property (
    (!o_rd_n || !o_wr_n) |-> o_cpu_busy && o_addr_lo_oe) else $error("strobe outside a move");
  write_data_a: assert property (
    !o_wr_n |-> o_data_oe) else $error("write strobe without data");
  lead_cycles_a: assert property (
    $fell(o_rd_n) || $fell(o_wr_n) |-> $past(o_cpu_busy, 2)) else $error("lead too short");
  tail_cycles_a: assert property (
    $rose(o_rd_n) || $rose(o_wr_n) |-> o_cpu_busy [*2]) else $error("tail too short");
  done_bound_a: assert property (
    $fell(o_rd_n) || $fell(o_wr_n) |-> ##[1:40] o_cpu_done) else $error("move never done");
  done_pulse_a: assert property (
    o_cpu_done |-> !o_cpu_busy && $past(o_cpu_busy) ##1 !o_cpu_done) else $error("bad done");
  move_accept_a: assert property (
    i_cpu_req && !o_cpu_busy && !o_cpu_done |=> o_cpu_busy) else $error("request not taken");
  latch_len_a: assert property (
    $rose(o_ale) |-> o_ale [*2]) else $error("latch strobe too short");
  apb_answer_a: assert property (
    i_psel && i_penable && !o_pready |=> o_pready) else $error("no apb answer");
  apb_error_a: assert property (
    o_pslverr |-> o_pready) else $error("error without ready");
  cover property ($fell(o_rd_n));
  cover property ($rose(o_ale));
  cover property (o_pslverr);
endmodule // emimt_properties
bind emif_core emimt_properties i_props (.i_clock, .i_rst, .i_psel, .i_penable, .i_cpu_req, .o_pready,
  .o_pslverr, .o_cpu_busy, .o_cpu_done, .o_rd_n, .o_wr_n, .o_data_oe, .o_addr_lo_oe, .o_ale);

/* ext_mem_iface_mapping_timing_tb.sv */
// Self-checking bench of the external memory interface
`timescale 1ns/100ps
`include "emif_regs.vh"
module ext_mem_iface_mapping_timing_tb;
  logic        i_clock = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic        i_cpu_req = 0, i_cpu_wr = 0, i_cpu_wide = 0;
  logic [7:0]  i_paddr = 0, i_cpu_ptr = 0, i_cpu_wdata = 0, i_port_hi = 8'ha5;
  logic [31:0] i_pwdata = 0, o_prdata, rd;
  logic [15:0] i_cpu_data_pointer = 0, o_addr, sa;
  logic [7:0]  o_cpu_rdata, o_data, i_data;
  logic        o_pready, o_pslverr, o_cpu_busy, o_cpu_done, o_addr_hi_oe, o_addr_lo_oe;
  logic        o_data_oe, o_ale, o_rd_n, o_wr_n, err, stb, hoe;
  int          bad_count = 0, tests_run = 0, cnt;
  emif_core i_dut (.i_clock, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_cpu_req, .i_cpu_wr, .i_cpu_wide, .i_cpu_data_pointer, .i_cpu_ptr, .i_cpu_wdata,
    .o_cpu_busy, .o_cpu_done, .o_cpu_rdata, .i_port_hi, .o_addr, .o_addr_hi_oe, .o_addr_lo_oe,
    .o_data, .o_data_oe, .i_data, .o_ale, .o_rd_n, .o_wr_n);
  emimt_mem i_mem (.i_clock, .i_addr(o_addr), .i_data(o_data), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
    .o_data(i_data));
  always #4 i_clock = ~i_clock;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clock);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    err = o_pslverr;
    chk(o_pready, 1'b1);
    i_psel <= 0;
    i_penable <= 0;
  endtask
  // Runs one move and records strobes, address and length
  task automatic mv(input logic w, input logic wide, input logic [15:0] dp, input logic [7:0] p,
                    input logic [7:0] wd);
    @(posedge i_clock);
    i_cpu_req <= 1;
    i_cpu_wr <= w;
    i_cpu_wide <= wide;
    i_cpu_data_pointer <= dp;
    i_cpu_ptr <= p;
    i_cpu_wdata <= wd;
    cnt = 0;
    stb = 0;
    do begin
      @(posedge i_clock);
      cnt++;
      if (o_cpu_busy === 1'b1) i_cpu_req <= 0;
      if (o_rd_n === 1'b0 || o_wr_n === 1'b0) begin
        stb = 1;
        sa = o_addr;
        hoe = o_addr_hi_oe;
      end
    end while (o_cpu_done !== 1'b1 && cnt < 60);
    chk(o_cpu_done, 1'b1);
  endtask
  task automatic t_regs;
    apb(0, `EMIF_REG_CFG, 0);
    chk(rd, 32'h03);
    apb(0, `EMIF_REG_TMG, 0);
    chk(rd, 32'hff);
    apb(0, 8'h10, 0);
    chk({rd[0], err}, 2'b01);
    // On-chip-only mode at reset: a move never reaches the bus
    mv(1, 1, 16'h2345, 8'h00, 8'h66);
    chk({stb, cnt[7:0]}, {1'b0, 8'd3});
    $display("test regs done");
  endtask
  task automatic t_ext;
    apb(1, `EMIF_REG_CFG, 32'h0c);
    mv(1, 0, 16'h0000, 8'h34, 8'h77);
    chk({stb, hoe, sa}, {2'b10, 16'ha534});
    chk(cnt, 28);
    apb(0, `EMIF_REG_STAT, 0);
    chk({rd[15:8], rd[1]}, {8'd26, 1'b1});
    mv(1, 1, 16'h0010, 8'h00, 8'h11);
    chk({stb, hoe, sa}, {2'b11, 16'h0010});
    $display("test ext done");
  endtask
  task automatic t_split;
    apb(1, `EMIF_REG_CFG, 32'h08);
    apb(1, `EMIF_REG_TMG, 32'h14);
    apb(1, `EMIF_REG_PAGE, 32'h20);
    mv(1, 0, 16'h0000, 8'h10, 8'h5a);
    chk({stb, hoe, sa}, {2'b11, 16'h2010});
    mv(0, 0, 16'h0000, 8'h10, 8'h00);
    chk({o_cpu_rdata, cnt[7:0]}, {8'h5a, 8'd12});
    apb(1, `EMIF_REG_PAGE, 32'h0f);
    mv(1, 0, 16'h0000, 8'hff, 8'hc3);
    chk(stb, 0);
    mv(0, 1, 16'h0fff, 8'h00, 8'h00);
    chk({stb, o_cpu_rdata}, {1'b0, 8'hc3});
    mv(1, 1, 16'h1000, 8'h00, 8'h3c);
    chk({stb, hoe, sa}, {2'b11, 16'h1000});
    // Split mode without bank select leaves the upper pins to the port latch on an 8-bit move
    apb(1, `EMIF_REG_CFG, 32'h04);
    apb(1, `EMIF_REG_PAGE, 32'h30);
    mv(1, 0, 16'h0000, 8'h21, 8'h00);
    chk({stb, hoe, sa}, {2'b10, 16'ha521});
    $display("test split done");
  endtask
  task automatic t_min;
    logic [7:0] cf [4] = '{8'h0c, 8'h1c, 8'h1d, 8'h0c};
    logic [7:0] tm [4] = '{8'h00, 8'h00, 8'h00, 8'h45};
    int nn [4] = '{5, 7, 8, 8};
    for (int k = 0; k < 4; k++) begin
      apb(1, `EMIF_REG_CFG, {24'h0, cf[k]});
      apb(1, `EMIF_REG_TMG, {24'h0, tm[k]});
      mv(1, 1, 16'h2000, 8'h00, 8'h00);
      chk(cnt, nn[k] + 2);
      apb(0, `EMIF_REG_STAT, 0);
      chk(rd[15:8], nn[k]);
    end
    $display("test timing done");
  endtask
  // Reset in mid-run brings back the largest timing
  task automatic t_rst;
    @(posedge i_clock);
    i_rst <= 1;
    repeat (2) @(posedge i_clock);
    i_rst <= 0;
    apb(0, `EMIF_REG_TMG, 0);
    chk(rd, 32'hff);
    apb(0, `EMIF_REG_CFG, 0);
    chk(rd, 32'h03);
    $display("test reset done");
  endtask
  task automatic close_out;
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst <= 0;
    t_regs();
    t_ext();
    t_split();
    t_min();
    t_rst();
    close_out();
  end
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule // ext_mem_iface_mapping_timing_tb
